// *** logic/ftc_pkg.sv ***
// Package with register addresses, field positions and shared types of the feedback table control block.
package ftc_pkg;
  localparam logic [15:0] ADDR_FEEDBACK_TABLE_POINTER = 16'h17D0;
  localparam logic [15:0] ADDR_FEEDBACK_ENABLE_CONFIG = 16'h17D1;
  localparam logic [15:0] ADDR_PACKAGE_THERMAL_STATUS = 16'h01B1;
  localparam logic [15:0] ADDR_PACKAGE_THERMAL_IRQ_ENABLE = 16'h01B2;
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_MULTI_BIT = 1;
  localparam int PTR_VALID_BIT = 0;
  localparam int PTR_ADDR_LSB = 12;
  localparam int STATUS_CHANGE_BIT = 26;
  localparam int IRQ_ENABLE_BIT = 25;
  localparam logic [63:0] CONFIG_RESET = 64'h0;
  localparam logic [63:0] POINTER_RESET = 64'h0;
  localparam logic [63:0] POINTER_WMASK = 64'hFFFF_FFFF_FFFF_F001;
  localparam logic [63:0] CONFIG_WMASK = 64'h0000_0000_0000_0003;
  localparam logic [7:0] FILL_CYCLES = 8'h10;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [63:0] wdata;
  } ftc_req_t;

  typedef struct packed {
    logic single_fill;
    logic multi_fill;
  } ftc_fill_t;

  typedef enum logic [1:0] {
    FTC_IDLE = 2'b00,
    FTC_FILL = 2'b01,
    FTC_RUN = 2'b10
  } ftc_state_t;
endpackage : ftc_pkg

// *** logic/ftc_edge.sv ***
// Rising edge detector on a single control level.
`timescale 1ns/1ps
`default_nettype none
module ftc_edge (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic level,
  output logic rise
);
  logic prev_ff;
  logic nxt_prev;

  always_comb begin
    nxt_prev = level;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  assign rise = level & ~prev_ff;
endmodule : ftc_edge
`default_nettype wire

// *** logic/ftc_fill.sv ***
// Table fill sequencer: counts a fixed fill time and reports completion.
`timescale 1ns/1ps
`default_nettype none
module ftc_fill (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic busy_ff;
  logic nxt_busy;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    if (abort) begin
      nxt_busy = 1'b0;
      nxt_cnt = 8'h00;
    end else if (start) begin
      nxt_busy = 1'b1;
      nxt_cnt = ftc_pkg::FILL_CYCLES;
    end else if (busy_ff) begin
      nxt_cnt = cnt_ff - 8'h01;
      if (cnt_ff == 8'h01) begin
        nxt_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 8'h00;
      busy_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

  assign busy = busy_ff;
  assign done = busy_ff & (cnt_ff == 8'h01) & ~abort & ~start;
endmodule : ftc_fill
`default_nettype wire

// *** logic/ftc_top.sv ***
// Feedback table configuration, population control and change notification.
//
// Function
// [R1] Config register at 17D1H, reset zero, INIT keeps.
// [R2] Bit 0 enables single-class feedback.
// [R3] Multi-class needs bits 0 and 1.
// [R4] Bit 0 only fills class 0 entries.
// [R5] Multi-class filled at once, updated at run time.
// [R6] Table ready sets change flag bit 26.
// [R7] Interrupt only when enable bit 25 set.
// [R8] Clearing bit 1 alone sets no flag.
// [R9] Bit 0 zero disables both functions.
// [R10] Bit 1 without bit 0 ignored silently.
// [R11] Clearing bit 0 acknowledged by flag, writes stop.
// [R12] Software waits for flag before reusing memory.
// [R13] Software programs pointer before enabling.
// [R14] Software disables only after init flag.
// [R15] Bit 1 without support raises protection fault.
// [R16] Pair 10 to 00 takes no action.
// [R17] Change flag sticky, cleared by writing zero.
// [R18] No table updates while flag set.
// [R19] Interrupt enable bit is read/write.
// [R20] Enable rising edge gives initial notification.
// [R21] Pointer register 17D0H with valid bit 0.
// [R22] Interrupt is one-cycle pulse on flag rise.
`timescale 1ns/1ps
`default_nettype none
module ftc_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic init_event,
  input wire logic multi_class_supported,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic hw_update_req,
  output logic [63:0] reg_rdata,
  output logic reg_ack,
  output logic general_protection_fault,
  output logic single_class_active,
  output logic multi_class_active,
  output logic table_write_en,
  output logic class0_write,
  output logic multi_class_write,
  output logic [63:0] table_base,
  output logic thermal_irq
);
  ftc_pkg::ftc_req_t req;
  ftc_pkg::ftc_fill_t fill_ff, nxt_fill;
  ftc_pkg::ftc_state_t state_ff, nxt_state;
  logic [63:0] cfg_ff, nxt_cfg;
  logic [63:0] ptr_ff, nxt_ptr;
  logic flag_ff, nxt_flag;
  logic irq_en_ff, nxt_irq_en;
  logic irq_ff, nxt_irq;
  logic gp_ff, nxt_gp;
  logic [63:0] rdata_ff, nxt_rdata;
  logic ack_ff, nxt_ack;
  logic wr_cfg, wr_ptr, wr_status, wr_irq;
  logic old_b0, old_b1, new_b0, new_b1;
  logic cfg_accept, cfg_fault;
  logic fill_start, fill_abort, fill_busy, fill_done;
  logic ack_disable, irq_en_rise, flag_set;

  assign req.wr = reg_wr;
  assign req.rd = reg_rd;
  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;

  assign wr_cfg = req.wr & (req.addr == ftc_pkg::ADDR_FEEDBACK_ENABLE_CONFIG); // R1
  assign wr_ptr = req.wr & (req.addr == ftc_pkg::ADDR_FEEDBACK_TABLE_POINTER); // R21
  assign wr_status = req.wr & (req.addr == ftc_pkg::ADDR_PACKAGE_THERMAL_STATUS);
  assign wr_irq = req.wr & (req.addr == ftc_pkg::ADDR_PACKAGE_THERMAL_IRQ_ENABLE);

  assign old_b0 = cfg_ff[ftc_pkg::CFG_ENABLE_BIT];
  assign old_b1 = cfg_ff[ftc_pkg::CFG_MULTI_BIT];
  assign new_b0 = req.wdata[ftc_pkg::CFG_ENABLE_BIT];
  assign new_b1 = req.wdata[ftc_pkg::CFG_MULTI_BIT];

  // A write setting bit 1 without support faults and leaves the register alone.
  assign cfg_fault = wr_cfg & new_b1 & ~multi_class_supported; // R15
  assign cfg_accept = wr_cfg & ~cfg_fault;

  // Transitions into or out of an enabled state decide fill and acknowledge.
  always_comb begin
    fill_start = 1'b0;
    ack_disable = 1'b0;
    fill_abort = 1'b0;
    nxt_fill = fill_ff;
    if (cfg_accept) begin
      if (new_b0) begin
        if (!old_b0) begin
          fill_start = 1'b1; // R2
          nxt_fill.single_fill = 1'b1; // R4
          nxt_fill.multi_fill = new_b1; // R5
        end else if (new_b1 && !old_b1) begin
          fill_start = 1'b1; // R5
          nxt_fill.multi_fill = 1'b1;
        end else if (!new_b1 && old_b1) begin
          nxt_fill.multi_fill = 1'b0; // R8
        end
      end else begin
        fill_abort = 1'b1; // R9
        nxt_fill = '0;
        ack_disable = old_b0; // R11 R10 R16
      end
    end
  end

  ftc_fill u_fill (
    .clk(clk),
    .reset_n(reset_n),
    .start(fill_start),
    .abort(fill_abort),
    .busy(fill_busy),
    .done(fill_done)
  );

  ftc_edge u_irq_edge (
    .clk(clk),
    .reset_n(reset_n),
    .level(irq_en_ff),
    .rise(irq_en_rise)
  );

  // Run-time updates are accepted only while enabled, not filling, and the flag is clear.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ftc_pkg::FTC_IDLE: begin
        if (fill_start) begin
          nxt_state = ftc_pkg::FTC_FILL;
        end
      end
      ftc_pkg::FTC_FILL: begin
        if (fill_abort) begin
          nxt_state = ftc_pkg::FTC_IDLE;
        end else if (fill_done) begin
          nxt_state = ftc_pkg::FTC_RUN;
        end
      end
      ftc_pkg::FTC_RUN: begin
        if (fill_abort) begin
          nxt_state = ftc_pkg::FTC_IDLE;
        end else if (fill_start) begin
          nxt_state = ftc_pkg::FTC_FILL;
        end
      end
      default: begin
        nxt_state = ftc_pkg::FTC_IDLE;
      end
    endcase
  end

  assign table_write_en = ~flag_ff & (fill_busy | (state_ff == ftc_pkg::FTC_RUN & hw_update_req)); // R18 R11
  assign class0_write = table_write_en & fill_ff.single_fill; // R4
  assign multi_class_write = table_write_en & fill_ff.multi_fill; // R5

  assign flag_set = fill_done | ack_disable | irq_en_rise
    | (state_ff == ftc_pkg::FTC_RUN & hw_update_req & ~flag_ff); // R6 R11 R20

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_ptr = ptr_ff;
    nxt_irq_en = irq_en_ff;
    nxt_flag = flag_ff;
    nxt_gp = cfg_fault; // R15
    if (cfg_accept) begin
      nxt_cfg = req.wdata & ftc_pkg::CONFIG_WMASK; // R1
    end
    if (wr_ptr) begin
      nxt_ptr = req.wdata & ftc_pkg::POINTER_WMASK; // R21
    end
    if (wr_irq) begin
      nxt_irq_en = req.wdata[ftc_pkg::IRQ_ENABLE_BIT]; // R19
    end
    // Writing one is ignored; a hardware set in the same cycle beats the clear.
    if (wr_status && !req.wdata[ftc_pkg::STATUS_CHANGE_BIT]) begin
      nxt_flag = 1'b0; // R17
    end
    if (flag_set) begin
      nxt_flag = 1'b1; // R17
    end
    nxt_irq = nxt_flag & ~flag_ff & irq_en_ff; // R7 R22
    if (irq_en_rise) begin
      nxt_irq = 1'b1; // R20
    end
  end

  always_comb begin
    nxt_ack = req.wr | req.rd;
    nxt_rdata = 64'h0;
    if (req.rd) begin
      unique case (req.addr)
        ftc_pkg::ADDR_FEEDBACK_ENABLE_CONFIG: nxt_rdata = cfg_ff;
        ftc_pkg::ADDR_FEEDBACK_TABLE_POINTER: nxt_rdata = ptr_ff;
        ftc_pkg::ADDR_PACKAGE_THERMAL_STATUS: nxt_rdata[ftc_pkg::STATUS_CHANGE_BIT] = flag_ff;
        ftc_pkg::ADDR_PACKAGE_THERMAL_IRQ_ENABLE: nxt_rdata[ftc_pkg::IRQ_ENABLE_BIT] = irq_en_ff;
        default: nxt_rdata = 64'h0;
      endcase
    end
  end

  // INIT is deliberately not a reset term: the configuration survives it.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff <= ftc_pkg::CONFIG_RESET; // R1
      ptr_ff <= ftc_pkg::POINTER_RESET;
      flag_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      irq_ff <= 1'b0;
      gp_ff <= 1'b0;
      rdata_ff <= 64'h0;
      ack_ff <= 1'b0;
      fill_ff <= '0;
      state_ff <= ftc_pkg::FTC_IDLE;
    end else begin
      cfg_ff <= nxt_cfg;
      ptr_ff <= nxt_ptr;
      flag_ff <= nxt_flag;
      irq_en_ff <= nxt_irq_en;
      irq_ff <= nxt_irq;
      gp_ff <= nxt_gp;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      fill_ff <= nxt_fill;
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_ack = ack_ff;
  assign general_protection_fault = gp_ff;
  assign single_class_active = old_b0; // R2 R9
  assign multi_class_active = old_b0 & old_b1; // R3
  assign table_base = {ptr_ff[63:ftc_pkg::PTR_ADDR_LSB], {ftc_pkg::PTR_ADDR_LSB{1'b0}}};
  assign thermal_irq = irq_ff;

  logic unused_init;
  assign unused_init = init_event & ptr_ff[ftc_pkg::PTR_VALID_BIT];
endmodule : ftc_top
`default_nettype wire

// *** verif/ftc_checker.sv ***
// Concurrent checks on the ports of the feedback table control block.
`timescale 1ns/1ps
`default_nettype none
module ftc_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic multi_class_supported,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic general_protection_fault,
  input wire logic single_class_active,
  input wire logic multi_class_active,
  input wire logic table_write_en,
  input wire logic class0_write,
  input wire logic multi_class_write,
  input wire logic [63:0] table_base,
  input wire logic thermal_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic cfg_wr;
  assign cfg_wr = reg_wr && reg_addr == ftc_pkg::ADDR_FEEDBACK_ENABLE_CONFIG;
  a_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("no acknowledge after an access");
  a_ack_cause: assert property (reg_ack |-> $past(reg_wr) || $past(reg_rd))
    else $error("acknowledge without an access");
  a_enable_single: assert property (cfg_wr && reg_wdata[1:0] == 2'b01 |=> single_class_active && !multi_class_active)
    else $error("bit 0 alone did not enable single class only");
  a_multi_needs_both: assert property (multi_class_active |-> single_class_active)
    else $error("multi class active without enable");
  a_multi_enable: assert property (cfg_wr && reg_wdata[1:0] == 2'b11 && multi_class_supported
    |=> single_class_active && multi_class_active)
    else $error("both enable bits did not enable multi class");
  a_multi_write_gate: assert property (multi_class_write |-> multi_class_active)
    else $error("multi class column written while disabled");
  a_idle_quiet: assert property (!single_class_active |-> !table_write_en && !class0_write)
    else $error("table written while disabled");
  a_invalid_pair: assert property (cfg_wr && reg_wdata[1:0] == 2'b10 && !single_class_active
    |=> !single_class_active && !multi_class_active && !table_write_en)
    else $error("invalid enable pair had an effect");
  a_fault_refuse: assert property (cfg_wr && reg_wdata[1] && !multi_class_supported
    |=> general_protection_fault && $stable(single_class_active) && !multi_class_active)
    else $error("unsupported bit 1 write not refused");
  a_irq_pulse: assert property (thermal_irq |=> !thermal_irq)
    else $error("interrupt longer than one cycle");
  a_base_aligned: assert property (table_base[11:0] == 12'h000)
    else $error("table base not page aligned");
  c_single: cover property ($rose(single_class_active));
  c_multi: cover property ($rose(multi_class_active));
  c_irq: cover property (thermal_irq);
  c_fault: cover property (general_protection_fault);
endmodule : ftc_checker
bind ftc_top ftc_checker u_chk (.clk, .reset_n, .multi_class_supported, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_ack, .general_protection_fault, .single_class_active, .multi_class_active, .table_write_en, .class0_write,
  .multi_class_write, .table_base, .thermal_irq);
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the feedback table control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, reset_n, init_event, multi_class_supported, reg_wr, reg_rd, hw_update_req;
  logic [15:0] reg_addr;
  logic [63:0] reg_wdata, reg_rdata, table_base, v;
  logic reg_ack, general_protection_fault, single_class_active, multi_class_active;
  logic table_write_en, class0_write, multi_class_write, thermal_irq;
  int err_count = 0;
  int samples_checked = 0;
  int irqs = 0;
  int faults = 0;
  int cyc = 0;
  localparam logic [15:0] CFG = ftc_pkg::ADDR_FEEDBACK_ENABLE_CONFIG;
  localparam logic [15:0] PTR = ftc_pkg::ADDR_FEEDBACK_TABLE_POINTER;
  localparam logic [15:0] STS = ftc_pkg::ADDR_PACKAGE_THERMAL_STATUS;
  localparam logic [15:0] IEN = ftc_pkg::ADDR_PACKAGE_THERMAL_IRQ_ENABLE;
  ftc_top dut (.clk, .reset_n, .init_event, .multi_class_supported, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .hw_update_req, .reg_rdata, .reg_ack, .general_protection_fault, .single_class_active, .multi_class_active,
    .table_write_en, .class0_write, .multi_class_write, .table_base, .thermal_irq);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Requests rise one falling edge and drop the next, so the design samples them at exactly one rising edge.
  task automatic wr(input logic [15:0] a, input logic [63:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    v = (reg_ack === 1'b1) ? reg_rdata : 'x;
  endtask : rd
  task automatic flag(input logic e);
    rd(STS);
    chk(64'(v[ftc_pkg::STATUS_CHANGE_BIT]), 64'(e));
  endtask : flag
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  always @(posedge clk) begin
    cyc++;
    if (thermal_irq === 1'b1) irqs++;
    if (general_protection_fault === 1'b1) faults++;
    if (cyc == 3000) begin
      err_count++;
      $display("MISMATCH t=%0t timeout", $time);
      stop_test();
    end
  end
  initial begin
    reset_n = 1'b0;
    init_event = 1'b0;
    multi_class_supported = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 64'h0;
    hw_update_req = 1'b0;
    idle(2);
    reset_n = 1'b1;
    rd(CFG);
    chk(v, 64'h0);
    rd(PTR);
    chk(v, 64'h0);
    wr(PTR, 64'h0000_0000_1234_5FFF);
    rd(PTR);
    chk(v, 64'h0000_0000_1234_5001);
    chk(table_base, 64'h0000_0000_1234_5000);
    wr(IEN, 64'h0000_0000_0200_0000);
    idle(3);
    chk(64'(irqs), 64'h1);
    flag(1'b1);
    rd(IEN);
    chk(64'(v[25]), 64'h1);
    wr(STS, 64'h0000_0000_0400_0000);
    flag(1'b1);
    wr(STS, 64'h0);
    flag(1'b0);
    wr(CFG, 64'h1);
    chk(64'({single_class_active, multi_class_active, table_write_en, class0_write, multi_class_write}), 64'h16);
    idle(10);
    flag(1'b0);
    idle(6);
    flag(1'b1);
    chk(64'(irqs), 64'h2);
    hw_update_req = 1'b1;
    idle(2);
    chk(64'(table_write_en), 64'h0);
    wr(STS, 64'h0);
    idle(2);
    hw_update_req = 1'b0;
    flag(1'b1);
    wr(STS, 64'h0);
    wr(CFG, 64'h3);
    chk(64'({single_class_active, multi_class_active}), 64'h3);
    chk(64'({table_write_en, class0_write, multi_class_write}), 64'h7);
    idle(20);
    flag(1'b1);
    wr(STS, 64'h0);
    wr(CFG, 64'h1);
    chk(64'({single_class_active, multi_class_active}), 64'h2);
    idle(20);
    flag(1'b0);
    wr(CFG, 64'h0);
    chk(64'({single_class_active, table_write_en}), 64'h0);
    flag(1'b1);
    wr(STS, 64'h0);
    wr(CFG, 64'h2);
    idle(20);
    chk(64'({single_class_active, multi_class_active}), 64'h0);
    flag(1'b0);
    wr(CFG, 64'h0);
    idle(20);
    flag(1'b0);
    chk(64'(irqs), 64'h5);
    multi_class_supported = 1'b0;
    wr(CFG, 64'h3);
    idle(1);
    chk(64'(faults), 64'h1);
    rd(CFG);
    chk(v, 64'h0);
    wr(IEN, 64'h0);
    wr(CFG, 64'h1);
    idle(20);
    flag(1'b1);
    chk(64'(irqs), 64'h5);
    init_event = 1'b1;
    idle(1);
    init_event = 1'b0;
    rd(CFG);
    chk(v, 64'h1);
    reset_n = 1'b0;
    idle(2);
    reset_n = 1'b1;
    rd(CFG);
    chk(v, 64'h0);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
